/* File: rtl/dacsf_regs.svh */
// Constants for the serial write front end.
`ifndef DACSF_REGS_SVH
`define DACSF_REGS_SVH
`define DACSF_FRAME_BITS 24
`define DACSF_CNT_W 5
`define DACSF_CODE_W 16
`define DACSF_MODE_HI_POS 17
`define DACSF_MODE_LO_POS 16
`define DACSF_CODE_RST 16'h0000
`define DACSF_MODE_RST 2'h0
`endif

/* File: rtl/dacsf_pkg.sv */
// Types for the serial write front end.
package dacsf_pkg;
    typedef enum logic [1:0] {
        DACSF_PM_NORMAL = 2'h0,
        DACSF_PM_1K = 2'h1,
        DACSF_PM_100K = 2'h2,
        DACSF_PM_HIZ = 2'h3
    } dacsf_pmode_type;
    typedef enum logic [1:0] {
        DACSF_IDLE = 2'h1,
        DACSF_SHIFT = 2'h2
    } dacsf_state_type;
    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic sdi;
    } dacsf_link_type;
    typedef struct packed {
        logic [15:0] code;
        dacsf_pmode_type mode;
    } dacsf_out_type;
endpackage

/* File: rtl/dacsf_sync.sv */
// Two-flop synchroniser for the three link pins.
module dacsf_sync (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire dacsf_pkg::dacsf_link_type pins_i,
    output dacsf_pkg::dacsf_link_type sync_o
);
    typedef struct packed {
        dacsf_pkg::dacsf_link_type s1;
        dacsf_pkg::dacsf_link_type s2;
    } dacsf_sync_state_type;
    dacsf_sync_state_type st_r;
    dacsf_sync_state_type st_nxt;
    always_comb begin
        st_nxt.s1 = pins_i;
        st_nxt.s2 = st_r.s1;
    end
    // Idle link levels at reset so no false edge is seen on release.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{s1: 3'h6, s2: 3'h6};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign sync_o = st_r.s2;
endmodule

/* File: rtl/dacsf_top.sv */
// Serial write front end of a 16-bit voltage-output converter.
// Functional notes
// - Sample data on each falling serial clock.
// - Frame select low opens frame, active low.
// - Load converter register after 24th edge.
// - Early frame select rise aborts frame.
// - Power-up output code zero until write.
// - Converter code is 16-bit straight binary.
// - Power mode changes only via frames.
// - Bits 17:16 select power-down mode.
// - Power-down frames also load converter code.
`include "dacsf_regs.svh"
module dacsf_top (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic sel_n_i,
    input wire logic sdi_i,
    output logic [15:0] dac_code_o,
    output dacsf_pkg::dacsf_pmode_type power_mode_o,
    output logic update_o
);
    typedef struct packed {
        dacsf_pkg::dacsf_state_type fsm;
        logic sclk_d;
        logic [`DACSF_FRAME_BITS-1:0] shreg;
        logic [`DACSF_CNT_W-1:0] cnt;
        logic [`DACSF_CODE_W-1:0] code;
        dacsf_pkg::dacsf_pmode_type mode;
        logic upd;
    } dacsf_state_type;
    dacsf_pkg::dacsf_link_type pins;
    dacsf_pkg::dacsf_link_type lnk;
    dacsf_state_type st_r;
    dacsf_state_type st_nxt;
    logic fall;
    logic [`DACSF_FRAME_BITS-1:0] shifted;
    assign pins = '{sclk: sclk_i, sel_n: sel_n_i, sdi: sdi_i};
    dacsf_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .pins_i(pins),
        .sync_o(lnk)
    );
    assign fall = st_r.sclk_d & ~lnk.sclk;
    assign shifted = {st_r.shreg[`DACSF_FRAME_BITS-2:0], lnk.sdi};
    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_d = lnk.sclk;
        st_nxt.upd = 1'b0;
        unique case (st_r.fsm)
            dacsf_pkg::DACSF_IDLE: begin
                if (!lnk.sel_n) begin
                    st_nxt.fsm = dacsf_pkg::DACSF_SHIFT;
                    st_nxt.cnt = '0;
                    st_nxt.shreg = '0;
                end
            end
            dacsf_pkg::DACSF_SHIFT: begin
                if (lnk.sel_n) begin
                    // Partial frame dropped; code and mode stay untouched.
                    st_nxt.fsm = dacsf_pkg::DACSF_IDLE;
                end else if (fall) begin
                    st_nxt.shreg = shifted;
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.cnt == 5'(`DACSF_FRAME_BITS - 1)) begin
                        st_nxt.code = shifted[`DACSF_CODE_W-1:0];
                        st_nxt.mode = dacsf_pkg::dacsf_pmode_type'(
                            {shifted[`DACSF_MODE_HI_POS], shifted[`DACSF_MODE_LO_POS]});
                        st_nxt.upd = 1'b1;
                        // Edges past the 24th fill a new frame, which loads on its own 24th edge or is dropped when select rises.
                        st_nxt.fsm = dacsf_pkg::DACSF_IDLE;
                        st_nxt.cnt = '0;
                    end
                end
            end
            default: st_nxt.fsm = dacsf_pkg::DACSF_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r.fsm <= dacsf_pkg::DACSF_IDLE;
            st_r.sclk_d <= 1'b1;
            st_r.shreg <= '0;
            st_r.cnt <= '0;
            st_r.code <= `DACSF_CODE_RST;
            st_r.mode <= dacsf_pkg::dacsf_pmode_type'(`DACSF_MODE_RST);
            st_r.upd <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end
    // Idle reopens a frame at once while select stays low, so stray edges after a
    // full frame start a new frame; it loads on its 24th edge or is discarded as a partial frame.
    assign dac_code_o = st_r.code;
    assign power_mode_o = st_r.mode;
    assign update_o = st_r.upd;
endmodule

/* File: verif/dacsf_monitor.sv */
// Checker on the ports of the serial write front end.
module dacsf_monitor (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic sel_n_i,
    input wire logic sdi_i,
    input wire logic [15:0] dac_code_o,
    input wire dacsf_pkg::dacsf_pmode_type power_mode_o,
    input wire logic update_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_code_on_load: assert property ($changed(dac_code_o) |-> update_o) else $error("code moved");
    a_mode_on_load: assert property ($changed(power_mode_o) |-> update_o) else $error("mode moved");
    a_load_pulse: assert property (update_o |=> !update_o) else $error("long load");
    a_idle_quiet: assert property (sel_n_i [*8] |=> !update_o) else $error("idle load");
    a_reset_zero: assert property (!$past(nrst_i) |-> dac_code_o == 16'h0000 && power_mode_o == 2'h0)
        else $error("reset value");
    a_load_clk_low: assert property (update_o |-> !sclk_i) else $error("load off edge");
    a_load_framed: assert property (update_o |-> $past(!sel_n_i, 2)) else $error("load unframed");
    a_load_holds: assert property (update_o |=> $stable(dac_code_o) [*2]) else $error("code lost");
endmodule
bind dacsf_top dacsf_monitor u_mon (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .sel_n_i(sel_n_i),
    .sdi_i(sdi_i), .dac_code_o(dac_code_o), .power_mode_o(power_mode_o), .update_o(update_o));

/* File: verif/dacsf_host.sv */
// Host model that writes frames over the three-wire link.
module dacsf_host (
    output logic sclk_o,
    output logic sel_n_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b1;
        sel_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // Clock stands high outside frames; data flips once released so it is never trusted stale.
    task automatic send(input logic [23:0] f, input int n);
        sel_n_o = 1'b0;
        #40;
        for (int i = 23; i > 23 - n; i--) begin
            sdi_o = f[i];
            #40 sclk_o = 1'b0;
            #40 sclk_o = 1'b1;
        end
        sel_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #100;
    endtask
endmodule

/* File: verif/tb.sv */
// Random frame bench for the serial write front end.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sclk, sel_n, sdi, upd;
    logic [15:0] code;
    dacsf_pkg::dacsf_pmode_type mode;
    logic [17:0] exp_out = 18'h00000;
    logic [31:0] rng = 32'h0000cda0;
    int fail_count = 0;
    int samples_checked = 0;
    int n_upd = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (upd === 1'b1) n_upd++;
    dacsf_host u_host (.sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(sdi));
    dacsf_top u_dacsf_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .sel_n_i(sel_n), .sdi_i(sdi),
        .dac_code_o(code), .power_mode_o(mode), .update_o(upd));
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // Short frames must leave the outputs alone.
    task automatic frame(input int n, input logic [1:0] m);
        rng = xorshift(rng);
        u_host.send({rng[23:18], m, rng[15:0]}, n);
        if (n == 24) exp_out = {m, rng[15:0]};
        check("outputs", {mode, code}, exp_out);
    endtask
    initial begin
        #200us;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (2) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        check("reset", {mode, code}, exp_out);
        for (int m = 0; m < 4; m++) frame(24, m[1:0]);
        frame(23, 2'h1);
        frame(1, 2'h2);
        repeat (6) frame(24, rng[9:8]);
        @(negedge sys_clk_i) nrst_i = 1'b0;
        exp_out = 18'h00000;
        @(negedge sys_clk_i) nrst_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        check("reset", {mode, code}, exp_out);
        frame(24, 2'h3);
        check("loads", n_upd[17:0], 18'h0000b);
        end_of_test();
    end
endmodule
